/* tcr_gate.sv */
// Gate value, single-pulse go/done bit and gate falling-edge detect.
// Assumes a synchronised gate level from the timer core.
`timescale 1ns/1ns
module tcr_gate (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   tcr_gate_if.gate g
);
   typedef struct packed {
      logic val;
      logic go;
   } tcr_gate_st_t;
   tcr_gate_st_t st_reg, st_next;
   logic cur;

   assign cur = g.polarity ? g.gate_level : ~g.gate_level;
   assign g.fall = st_reg.val & ~cur;
   assign g.gate_value = st_reg.val;
   assign g.go_done = st_reg.go;
   // With the gate enabled in single-pulse mode only one armed pulse may advance the count
   assign g.count_enable = ~g.enable | (st_reg.val & (~g.single_pulse | st_reg.go));

   always_comb begin
      st_next = st_reg;
      st_next.val = cur;
      if (g.go_clear_sw || (g.single_pulse && g.fall)) begin
         st_next.go = 1'b0;
      end
      // A fresh arm by software outranks a coincident hardware clear
      if (g.go_set) begin
         st_next.go = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   property p_go_clear;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && g.single_pulse && g.fall && !g.go_set |=> !g.go_done;
   endproperty
   a_go_clear: assert property (p_go_clear) else $error("go/done not cleared on gate fall");
endmodule

/* tcr_gate_if.sv */
// Signals between the timer core and its single-pulse gate logic.
// Assumes all signals live on sys_clk_i.
`timescale 1ns/1ns
interface tcr_gate_if;
   logic gate_level;
   logic enable;
   logic polarity;
   logic single_pulse;
   logic go_set;
   logic go_clear_sw;
   logic gate_value;
   logic count_enable;
   logic go_done;
   logic fall;
   modport core (output gate_level, enable, polarity, single_pulse, go_set, go_clear_sw,
                 input gate_value, count_enable, go_done, fall);
   modport gate (input gate_level, enable, polarity, single_pulse, go_set, go_clear_sw,
                 output gate_value, count_enable, go_done, fall);
endinterface

/* tcr_params.svh */
// Register offsets, field positions and reset values of the compare-reset timer.
// Assumes byte addressing on the register bus, one 32-bit word per register.
// Overview of operation
// - Special event trigger clears whole 16-bit count
// - Trigger-caused clear never sets overflow flag
// - Compare event flag raised independently of overflow
// - Compare value plus one gives the timer period
// - Asynchronous counting may lose a trigger
// - Count write in trigger cycle wins
// - Falling gate value clears go/done bit in single-pulse mode
// - Falling gate value sets gate event flag
// - Count wraps from maximum, sets overflow flag
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TCR_OFF_COUNT 5'h00
`define TCR_OFF_CMP 5'h04
`define TCR_OFF_CTRL 5'h08
`define TCR_OFF_STAT 5'h0c
`define TCR_OFF_MASK 5'h10

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define TCR_CTRL_ON 0
`define TCR_CTRL_SYNC 1
`define TCR_CTRL_SEVT 2
`define TCR_CTRL_GATE_EN 3
`define TCR_CTRL_POL 4
`define TCR_CTRL_SPM 5
`define TCR_CTRL_GO 6
`define TCR_CTRL_GVAL 7

// ----------------------------------------
// Status and mask field positions
// ----------------------------------------
`define TCR_ST_OVF 0
`define TCR_ST_GATE 1
`define TCR_ST_CMP 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCR_RST_COUNT 16'h0000
`define TCR_RST_CMP 16'hffff
`define TCR_RST_FLAGS 3'h0
`define TCR_COUNT_MAX 16'hffff

`endif

/* tcr_pin_model.sv */
// Pin-side model of the timer's surroundings: external count clock and gate pin.
// Assumes the bench requests bursts and gate levels on sys_clk_i rising edges.
`timescale 1ns/1ns
module tcr_pin_model (
   input wire logic sys_clk_i,
   input wire logic ext_run_i,
   input wire logic gate_lvl_i,
   output logic ext_clk_o,
   output logic gate_pin_o
);
   logic [7:0] cnt_reg = 8'h00;
   initial ext_clk_o = 1'b0;
   initial gate_pin_o = 1'b0;
   // ----------------------------------------
   // Burst clock: one rise per eight cycles
   // ----------------------------------------
   // Stands still low between bursts so no stray edge is counted
   always @(posedge sys_clk_i) begin
      cnt_reg <= ext_run_i ? cnt_reg + 8'h01 : 8'h00;
      ext_clk_o <= ext_run_i & cnt_reg[2];
      gate_pin_o <= gate_lvl_i;
   end
endmodule

/* tcr_pkg.sv */
// Shared types of the compare-reset timer.
// Assumes the field positions of tcr_params.svh.
package tcr_pkg;
   typedef struct packed {
      logic pol;
      logic spm;
      logic gate_en;
      logic sevt_en;
      logic sync_mode;
      logic on;
   } tcr_ctrl_t;
   typedef logic [2:0] tcr_flags_t;
endpackage

/* tcr_sync.sv */
// Three-stage pin synchroniser with agreement filter and rise pulse.
// Assumes inputs are asynchronous to sys_clk_i.
`timescale 1ns/1ns
module tcr_sync #(
   parameter int W = 2
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } tcr_sync_st_t;
   tcr_sync_st_t st_reg, st_next;
   logic [W-1:0] agree;

   if (W < 1) begin : g_chk
      $error("tcr_sync width must be at least one");
   end

   // Stage one feeds only stage two; the filter looks at stages two and three
   assign agree = ~(st_reg.s2 ^ st_reg.s3);
   assign rise_o = agree & st_reg.s3 & ~st_reg.lvl;
   assign level_o = st_reg.lvl;

   always_comb begin
      st_next = st_reg;
      st_next.s1 = pin_i;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.lvl = (agree & st_reg.s3) | (~agree & st_reg.lvl);
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end
endmodule

/* tcr_top.sv */
// Compare-reset timer: 16-bit count, compare period, gate, Avalon-MM slave.
// Assumes pins ext_clk_i and gate_pin_i are asynchronous; the bus is on sys_clk_i.
`timescale 1ns/1ns
`include "tcr_params.svh"
module tcr_top
   import tcr_pkg::*;
#(
   parameter int CW = 16
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic ext_clk_i,
   input wire logic gate_pin_i,
   output logic sevt_o,
   output logic irq_o
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] cmp;
      tcr_ctrl_t ctrl;
      tcr_flags_t stat;
      tcr_flags_t mask;
      logic pend;
      logic mprev;
      logic ack;
      logic sevt;
      logic [31:0] rdata;
   } tcr_top_st_t;

   localparam tcr_ctrl_t CTRL_RESET = '{pol: 1'b0, spm: 1'b0, gate_en: 1'b0,
                                        sevt_en: 1'b0, sync_mode: 1'b1, on: 1'b0};
   localparam tcr_top_st_t ST_RESET = '{count: `TCR_RST_COUNT, cmp: `TCR_RST_CMP,
                                        ctrl: CTRL_RESET, stat: `TCR_RST_FLAGS,
                                        mask: `TCR_RST_FLAGS, pend: 1'b0, mprev: 1'b0,
                                        ack: 1'b0, sevt: 1'b0, rdata: 32'h0000_0000};

   tcr_top_st_t st_reg, st_next;

   if (CW != 16) begin : g_chk
      $error("tcr_top count is two bytes wide");
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   function automatic logic [31:0] ctrl_word(input tcr_ctrl_t c, input logic go,
                                             input logic gval);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`TCR_CTRL_ON] = c.on;
      w[`TCR_CTRL_SYNC] = c.sync_mode;
      w[`TCR_CTRL_SEVT] = c.sevt_en;
      w[`TCR_CTRL_GATE_EN] = c.gate_en;
      w[`TCR_CTRL_POL] = c.pol;
      w[`TCR_CTRL_SPM] = c.spm;
      w[`TCR_CTRL_GO] = go;
      w[`TCR_CTRL_GVAL] = gval;
      return w;
   endfunction

   // ----------------------------------------
   // Pins and gate
   // ----------------------------------------
   logic [1:0] pin_lvl;
   logic [1:0] pin_rise;

   tcr_sync #(
      .W(2)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_i({gate_pin_i, ext_clk_i}),
      .level_o(pin_lvl),
      .rise_o(pin_rise)
   );

   tcr_gate_if gif ();

   tcr_gate u_gate (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .g(gif.gate)
   );

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic req;
   logic wr;
   logic wr_count;
   logic wr_cmp;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic [31:0] rd_mux;

   assign req = avs_read_i | avs_write_i;
   // Writes land on the edge that ends waitrequest, as the master samples it
   assign wr = st_reg.ack & avs_write_i;
   assign avs_waitrequest_o = req & ~st_reg.ack;
   assign avs_readdata_o = st_reg.rdata;

   always_comb begin
      wr_count = 1'b0;
      wr_cmp = 1'b0;
      wr_ctrl = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      rd_mux = 32'h0000_0000;
      if (avs_address_i == `TCR_OFF_COUNT) begin
         wr_count = wr & (|avs_byteenable_i[1:0]);
         rd_mux = {16'h0000, st_reg.count};
      end else if (avs_address_i == `TCR_OFF_CMP) begin
         wr_cmp = wr;
         rd_mux = {16'h0000, st_reg.cmp};
      end else if (avs_address_i == `TCR_OFF_CTRL) begin
         wr_ctrl = wr & avs_byteenable_i[0];
         rd_mux = ctrl_word(st_reg.ctrl, gif.go_done, gif.gate_value);
      end else if (avs_address_i == `TCR_OFF_STAT) begin
         wr_stat = wr & avs_byteenable_i[0];
         rd_mux = {29'h0000_0000, st_reg.stat};
      end else if (avs_address_i == `TCR_OFF_MASK) begin
         wr_mask = wr & avs_byteenable_i[0];
         rd_mux = {29'h0000_0000, st_reg.mask};
      end
   end

   assign gif.gate_level = pin_lvl[1];
   assign gif.enable = st_reg.ctrl.gate_en;
   assign gif.polarity = st_reg.ctrl.pol;
   assign gif.single_pulse = st_reg.ctrl.spm;
   assign gif.go_set = wr_ctrl & avs_writedata_i[`TCR_CTRL_GO];
   assign gif.go_clear_sw = wr_ctrl & ~avs_writedata_i[`TCR_CTRL_GO];

   // ----------------------------------------
   // Timer core
   // ----------------------------------------
   logic tick;
   logic match;
   logic pulse;
   logic sevt_reset;
   logic wrap;
   tcr_flags_t set_flags;

   // Synchronized mode counts every enabled clock; otherwise one count per pin rise
   assign tick = st_reg.ctrl.on & gif.count_enable & (st_reg.ctrl.sync_mode | pin_rise[0]);
   assign match = st_reg.ctrl.sevt_en & (st_reg.count == st_reg.cmp);
   assign pulse = match & ~st_reg.mprev;
   // A trigger is held for the next timer edge only in synchronized mode;
   // on the pin clock it is lost unless an edge lands in the same cycle
   assign sevt_reset = tick & (pulse | (st_reg.ctrl.sync_mode & st_reg.pend));
   assign wrap = tick & ~sevt_reset & (st_reg.count == `TCR_COUNT_MAX);
   assign sevt_o = st_reg.sevt;
   assign irq_o = |(st_reg.stat & st_reg.mask);

   always_comb begin
      set_flags = `TCR_RST_FLAGS;
      set_flags[`TCR_ST_OVF] = ~wr_count & wrap;
      set_flags[`TCR_ST_GATE] = gif.fall;
      set_flags[`TCR_ST_CMP] = pulse;
   end

   always_comb begin
      st_next = st_reg;
      st_next.mprev = match;
      st_next.sevt = pulse;
      st_next.pend = st_reg.ctrl.sync_mode & (pulse | st_reg.pend) & ~tick;
      st_next.ack = req & ~st_reg.ack;
      if (req && !st_reg.ack) begin
         st_next.rdata = rd_mux;
      end
      if (wr_count) begin
         st_next.count = merge16(st_reg.count, avs_writedata_i, avs_byteenable_i);
         st_next.pend = 1'b0;
      end else if (sevt_reset) begin
         st_next.count = 16'h0000;
      end else if (tick) begin
         st_next.count = st_reg.count + 16'h0001;
      end
      if (wr_cmp) begin
         st_next.cmp = merge16(st_reg.cmp, avs_writedata_i, avs_byteenable_i);
      end
      if (wr_ctrl) begin
         st_next.ctrl.on = avs_writedata_i[`TCR_CTRL_ON];
         st_next.ctrl.sync_mode = avs_writedata_i[`TCR_CTRL_SYNC];
         st_next.ctrl.sevt_en = avs_writedata_i[`TCR_CTRL_SEVT];
         st_next.ctrl.gate_en = avs_writedata_i[`TCR_CTRL_GATE_EN];
         st_next.ctrl.pol = avs_writedata_i[`TCR_CTRL_POL];
         st_next.ctrl.spm = avs_writedata_i[`TCR_CTRL_SPM];
      end
      if (wr_mask) begin
         st_next.mask = avs_writedata_i[2:0];
      end
      // Write-one-to-clear; a new event in the same cycle survives the clear
      if (wr_stat) begin
         st_next.stat = st_reg.stat & ~avs_writedata_i[2:0];
      end
      st_next.stat = st_next.stat | set_flags;
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_reg <= ST_RESET;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_sevt_clear;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && sevt_reset && !wr_count |=> st_reg.count == 16'h0000;
   endproperty
   a_sevt_clear: assert property (p_sevt_clear) else $error("trigger did not clear count");

   property p_no_ovf;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && sevt_reset && !st_reg.stat[`TCR_ST_OVF] |=> !st_reg.stat[`TCR_ST_OVF];
   endproperty
   a_no_ovf: assert property (p_no_ovf) else $error("trigger clear set overflow flag");

   property p_cmp_flag;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && pulse |=> st_reg.stat[`TCR_ST_CMP] && sevt_o;
   endproperty
   a_cmp_flag: assert property (p_cmp_flag) else $error("compare event flag missing");

   property p_period;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && st_reg.ctrl.sync_mode && match && tick && !wr_count && st_reg.cmp != 16'h0000
      |=> st_reg.count == 16'h0000;
   endproperty
   a_period: assert property (p_period) else $error("count ran past the compare period");

   property p_async_lost;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && !st_reg.ctrl.sync_mode && pulse && !tick |=> !st_reg.pend;
   endproperty
   a_async_lost: assert property (p_async_lost) else $error("async trigger was held");

   property p_write_wins;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && wr_count && sevt_reset && avs_byteenable_i[1:0] == 2'h3
      |=> st_reg.count == $past(avs_writedata_i[15:0]);
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("trigger beat a count write");

   property p_gate_flag;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && gif.fall |=> st_reg.stat[`TCR_ST_GATE];
   endproperty
   a_gate_flag: assert property (p_gate_flag) else $error("gate event flag not set");

   property p_wrap;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && wrap && !wr_count |=> st_reg.count == 16'h0000 && st_reg.stat[`TCR_ST_OVF];
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap did not clear count and flag");

   property p_replace;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && st_reg.ctrl.sync_mode && st_reg.pend && tick && !wr_count |=> st_reg.count == 16'h0000;
   endproperty
   a_replace: assert property (p_replace) else $error("held trigger not applied");

   // A trigger seen without a timer edge in synchronized mode waits for that edge
   property p_pend_hold;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && st_reg.ctrl.sync_mode && st_reg.pend && !tick && !wr_count |=> st_reg.pend;
   endproperty
   a_pend_hold: assert property (p_pend_hold) else $error("held trigger dropped early");

   property p_gate_sticky;
      @(posedge sys_clk_i) disable iff (rst_i)
      ce_i && st_reg.stat[`TCR_ST_GATE] && !(wr_stat && avs_writedata_i[`TCR_ST_GATE])
      |=> st_reg.stat[`TCR_ST_GATE];
   endproperty
   a_gate_sticky: assert property (p_gate_sticky) else $error("gate event flag lost");
endmodule

/* test_tcr_top.sv */
// Self-checking bench of the compare-reset timer through its Avalon-MM port.
// Assumes the one-wait-state slave answer and the register map of tcr_params.svh.
`timescale 1ns/1ns
`include "tcr_params.svh"
module test_tcr_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] adr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wait_o;
   logic ext_clk;
   logic gate_pin;
   logic sevt;
   logic irq;
   logic ext_run = 1'b0;
   logic ce = 1'b1;
   logic [31:0] w;
   logic gate_lvl = 1'b0;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   int t0;
   int t1;
   logic [31:0] v;
   always #20 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   tcr_top u_tcr_top (.sys_clk_i(clk), .rst_i(rst), .ce_i(ce), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .ext_clk_i(ext_clk),
      .gate_pin_i(gate_pin), .sevt_o(sevt), .irq_o(irq));
   tcr_pin_model u_tcr_pin_model (.sys_clk_i(clk), .ext_run_i(ext_run), .gate_lvl_i(gate_lvl),
      .ext_clk_o(ext_clk), .gate_pin_o(gate_pin));
   // ----------------------------------------
   // Bus cycles and comparisons
   // ----------------------------------------
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask
   // Request held until waitrequest is sampled low, then released at that edge
   task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      wdat <= d;
      wr <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (wait_o !== 1'b0 && n < 50);
      wr <= 1'b0;
      if (n >= 50) check_word(32'hdead, 32'h0);
      @(posedge clk);
   endtask
   task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      rd <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (wait_o !== 1'b0 && n < 50);
      d = rdat;
      rd <= 1'b0;
      if (n >= 50) check_word(32'hdead, 32'h0);
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus_rd(a, d);
      check_word(d, exp);
   endtask
   task automatic wait_sevt(output int t);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (sevt !== 1'b1 && n < 100);
      t = cyc;
      if (n >= 100) check_word(32'hdead, 32'h0);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(`TCR_OFF_COUNT, 32'h0000);
      rd_chk(`TCR_OFF_CMP, 32'hffff);
      rd_chk(`TCR_OFF_CTRL, 32'h0082);
      rd_chk(`TCR_OFF_MASK, 32'h0000);
      rd_chk(5'h14, 32'h0000);
      $display("test reset values done");
      // Compare value 3 in synchronized mode gives a period of four cycles
      bus_wr(`TCR_OFF_STAT, 32'h7);
      bus_wr(`TCR_OFF_CMP, 32'h0003);
      bus_wr(`TCR_OFF_CTRL, 32'h07);
      wait_sevt(t0);
      wait_sevt(t1);
      check_word(t1 - t0, 32'd4);
      wait_sevt(t0);
      check_word(t0 - t1, 32'd4);
      bus_wr(`TCR_OFF_CTRL, 32'h02);
      bus_rd(`TCR_OFF_STAT, v);
      check_bit(v[`TCR_ST_OVF], 1'b0);
      check_bit(v[`TCR_ST_CMP], 1'b1);
      bus_rd(`TCR_OFF_COUNT, v);
      check_bit(v[15:0] <= 16'h0003, 1'b1);
      $display("test period done");
      // Count write lands on the very edge that carries a trigger
      bus_wr(`TCR_OFF_COUNT, 32'h0010);
      bus_wr(`TCR_OFF_CMP, 32'h0012);
      bus_wr(`TCR_OFF_CTRL, 32'h07);
      bus_wr(`TCR_OFF_COUNT, 32'h0055);
      bus_wr(`TCR_OFF_CTRL, 32'h06);
      bus_rd(`TCR_OFF_COUNT, v);
      check_bit(v[15:0] > 16'h0055 && v[15:0] < 16'h0060, 1'b1);
      // A count write after the trigger drops the pending clear
      bus_wr(`TCR_OFF_CMP, 32'h0040);
      bus_wr(`TCR_OFF_CTRL, 32'h06);
      bus_wr(`TCR_OFF_COUNT, 32'h0040);
      bus_wr(`TCR_OFF_COUNT, 32'h0055);
      rd_chk(`TCR_OFF_COUNT, 32'h0055);
      bus_wr(`TCR_OFF_CTRL, 32'h07);
      bus_wr(`TCR_OFF_CTRL, 32'h06);
      bus_rd(`TCR_OFF_COUNT, v);
      check_bit(v[15:0] > 16'h0055 && v[15:0] < 16'h0060, 1'b1);
      // A trigger seen while stopped clears the count at the first tick
      bus_wr(`TCR_OFF_COUNT, 32'h0040);
      bus_wr(`TCR_OFF_CTRL, 32'h07);
      bus_wr(`TCR_OFF_CTRL, 32'h06);
      bus_rd(`TCR_OFF_COUNT, v);
      check_bit(v[15:0] < 16'h0010, 1'b1);
      $display("test write precedence done");
      // Wrap from the maximum raises the overflow flag and the interrupt
      bus_wr(`TCR_OFF_CTRL, 32'h02);
      bus_wr(`TCR_OFF_COUNT, 32'hfffe);
      bus_wr(`TCR_OFF_STAT, 32'h7);
      bus_wr(`TCR_OFF_MASK, 32'h1);
      check_bit(irq, 1'b0);
      bus_wr(`TCR_OFF_CTRL, 32'h03);
      // Two more timer edges reach the wrap before the status is latched
      repeat (2) @(posedge clk);
      rd_chk(`TCR_OFF_STAT, 32'h1);
      check_bit(irq, 1'b1);
      bus_rd(`TCR_OFF_COUNT, v);
      check_bit(v[15:0] < 16'h0010, 1'b1);
      bus_wr(`TCR_OFF_STAT, 32'h1);
      check_bit(irq, 1'b0);
      rd_chk(`TCR_OFF_STAT, 32'h0);
      $display("test overflow done");
      // Asynchronous counting misses the trigger and runs past the compare value
      bus_wr(`TCR_OFF_CTRL, 32'h02);
      bus_wr(`TCR_OFF_CMP, 32'h0002);
      bus_wr(`TCR_OFF_COUNT, 32'h0000);
      bus_wr(`TCR_OFF_CTRL, 32'h05);
      ext_run <= 1'b1;
      repeat (80) @(posedge clk);
      ext_run <= 1'b0;
      repeat (12) @(posedge clk);
      rd_chk(`TCR_OFF_COUNT, 32'h000a);
      bus_wr(`TCR_OFF_CTRL, 32'h06);
      $display("test async loss done");
      // Single-pulse gate: arm, then a falling gate value ends the measurement
      gate_lvl <= 1'b1;
      repeat (6) @(posedge clk);
      bus_wr(`TCR_OFF_CTRL, 32'h3b);
      bus_wr(`TCR_OFF_CTRL, 32'h7b);
      bus_wr(`TCR_OFF_STAT, 32'h7);
      bus_wr(`TCR_OFF_MASK, 32'h2);
      rd_chk(`TCR_OFF_CTRL, 32'hfb);
      check_bit(irq, 1'b0);
      gate_lvl <= 1'b0;
      repeat (8) @(posedge clk);
      rd_chk(`TCR_OFF_CTRL, 32'h3b);
      bus_rd(`TCR_OFF_STAT, v);
      check_bit(v[`TCR_ST_GATE], 1'b1);
      check_bit(irq, 1'b1);
      repeat (8) @(posedge clk);
      bus_rd(`TCR_OFF_STAT, v);
      check_bit(v[`TCR_ST_GATE], 1'b1);
      bus_wr(`TCR_OFF_STAT, 32'h2);
      bus_rd(`TCR_OFF_STAT, v);
      check_bit(v[`TCR_ST_GATE], 1'b0);
      $display("test gate pulse done");
      // Clock enable low freezes the running count
      bus_wr(`TCR_OFF_CTRL, 32'h03);
      bus_rd(`TCR_OFF_COUNT, v);
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      bus_rd(`TCR_OFF_COUNT, w);
      check_bit(w[15:0] - v[15:0] < 16'h0008, 1'b1);
      $display("test clock enable done");
      tally_and_finish();
   end
endmodule
